// ===== rtl/spca_pkg.sv
// Shared constants, types and 8b/10b encode helpers
package spca_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int MCLK_NS = 50;
	localparam int BIT_NS = 400;
	localparam int BIT_DIV = BIT_NS / MCLK_NS;
	localparam logic [3:0] BIT_DIV_LAST = 4'(BIT_DIV - 1);
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int LANES = 2;
	localparam logic [4:0] WORD_LAST = 5'h13;
	localparam logic [3:0] CHAR_LAST = 4'h9;
	localparam int DEPTH = 16;
	localparam logic [4:0] HALF = 5'h08;
	// ------------------------------------------------------------
	// Register indices and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ALIGN = 3'h1;
	localparam logic [2:0] REG_CORR = 3'h2;
	localparam logic [2:0] REG_THR = 3'h3;
	localparam logic [2:0] REG_STAT = 3'h4;
	localparam logic [17:0] CORR_RST = 18'h378b5;
	localparam logic [4:0] LOW_RST = 5'h06;
	localparam logic [4:0] HIGH_RST = 5'h0a;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ANY_POS, ANY_NEG, ANY_BOTH,
		K_POS, K_NEG, K_BOTH} spca_comma_type;
	typedef enum logic [2:0] {AL_OFF, AL_POS, AL_NEG, AL_BOTH,
		AL_USER} spca_align_type;
	typedef enum logic [1:0] {FILL = 2'b01, RUN = 2'b10} spca_state_type;
	typedef struct packed {
		logic [3:0]     repeatWait;
		spca_align_type alignSel;
		spca_comma_type commaSel;
		logic           decBypass;
		logic           encBypass;
	} spca_ctrl_type;
	typedef struct packed {
		logic [4:0] high;
		logic [4:0] low;
	} spca_thr_type;
	typedef struct packed {
		logic       ctrl;
		logic [7:0] data;
		logic       dispErr;
		logic       oobErr;
		logic       rd;
		logic       comma;
	} spca_lane_type;
	typedef spca_lane_type [LANES-1:0] spca_entry_type;
	// ------------------------------------------------------------
	// Code tables
	// ------------------------------------------------------------
	localparam logic [6:0] COMMA_POS = 7'h1f;
	localparam logic [6:0] COMMA_NEG = 7'h60;
	localparam logic [4:0] K28_X = 5'h1c;
	localparam logic [5:0] K28_SIX = 6'h0f;
	localparam logic [3:0] A7 = 4'h7;
	localparam logic [5:0] TAB6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31,
		6'h35, 6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d,
		6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a,
		6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e,
		6'h2b};
	localparam logic [3:0] TAB4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd,
		4'ha, 4'h6, 4'he};
	localparam logic [3:0] K28TAB [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2,
		4'ha, 4'h6, 4'h8};

	function automatic logic ctrl_legal(input logic [7:0] b);
		ctrl_legal = (b[4:0] == K28_X) || (b[7:5] == 3'h7 &&
			(b[4:0] == 5'h17 || b[4:0] == 5'h1b || b[4:0] == 5'h1d ||
			b[4:0] == 5'h1e));
	endfunction

	function automatic logic rd_after(input logic rd, input logic [9:0] c);
		rd_after = ($countones(c) > 5) ? 1'b1 :
			(($countones(c) < 5) ? 1'b0 : rd);
	endfunction

	function automatic logic [9:0] enc8b10b(input logic rd, input logic k,
		input logic [7:0] b);
		logic [4:0] x;
		logic [2:0] y;
		logic [5:0] six;
		logic [3:0] four;
		logic       rdMid;
		logic       alt;
		x = b[4:0];
		y = b[7:5];
		six = TAB6[x];
		rdMid = ($countones(six) == 3) ? rd : ~rd;
		if (rd && ($countones(six) != 3 || x == 5'h07)) six = ~six;
		alt = (y == 3'h7) && (k || (!rdMid && (x == 5'h11 ||
			x == 5'h12 || x == 5'h14)) || (rdMid && (x == 5'h0b ||
			x == 5'h0d || x == 5'h0e)));
		four = alt ? A7 : TAB4[y];
		if (rdMid && ($countones(four) != 2 || y == 3'h3)) four = ~four;
		if (k && x == K28_X)
			enc8b10b = rd ? ~{K28_SIX, K28TAB[y]} : {K28_SIX, K28TAB[y]};
		else
			enc8b10b = {six, four};
	endfunction
endpackage

// ===== rtl/spca_dec_if.sv
// Carrier between the receive path and one lane decoder
interface spca_dec_if;
	logic                     bypass;
	spca_pkg::spca_comma_type commaSel;
	logic [9:0]               code;
	logic                     rdIn;
	spca_pkg::spca_lane_type  lane;
	modport dec(input bypass, commaSel, code, rdIn, output lane);
	modport user(output bypass, commaSel, code, rdIn, input lane);
endinterface

// ===== rtl/spca_decoder.sv
// One-lane 8b/10b character decoder with comma detection
module spca_decoder (
	spca_dec_if.dec d
);
	logic [8:0] goodVal;
	logic [8:0] badVal;
	logic       good;
	logic       bad;
	logic [8:0] cand;
	wire        pos = d.code[9:3] == spca_pkg::COMMA_POS;
	wire        neg = d.code[9:3] == spca_pkg::COMMA_NEG;
	wire [8:0]  val = good ? goodVal : badVal;
	wire        legal = good | bad;
	wire        kComma = legal && val[8] && val[4:0] == spca_pkg::K28_X &&
		(val[7:5] == 3'h1 || val[7:5] == 3'h5 || val[7:5] == 3'h7);
	logic       commaHit;

	always_comb begin
		good = 1'b0;
		bad = 1'b0;
		goodVal = 9'h000;
		badVal = 9'h000;
		cand = 9'h000;
		for (int i = 0; i < 512; i++) begin
			cand = 9'(i);
			if (!cand[8] || spca_pkg::ctrl_legal(cand[7:0])) begin
				if (spca_pkg::enc8b10b(d.rdIn, cand[8], cand[7:0]) == d.code) begin
					good = 1'b1;
					goodVal = cand;
				end else if (spca_pkg::enc8b10b(~d.rdIn, cand[8], cand[7:0]) ==
					d.code) begin
					bad = 1'b1;
					badVal = cand;
				end
			end
		end
	end

	always_comb begin
		unique case (d.commaSel)
			spca_pkg::ANY_POS:  commaHit = pos;
			spca_pkg::ANY_NEG:  commaHit = neg;
			spca_pkg::ANY_BOTH: commaHit = pos | neg;
			spca_pkg::K_POS:    commaHit = kComma & pos;
			spca_pkg::K_NEG:    commaHit = kComma & neg;
			spca_pkg::K_BOTH:   commaHit = kComma;
			default:            commaHit = 1'b0;
		endcase
	end

	// Raw, out-of-table or decoded presentation
	assign d.lane.ctrl = (d.bypass || !legal) ? d.code[9] : val[8];
	assign d.lane.data = (d.bypass || !legal) ? d.code[7:0] : val[7:0];
	assign d.lane.dispErr = !d.bypass && !good && bad;
	assign d.lane.oobErr = !d.bypass && !legal;
	assign d.lane.rd = d.bypass ? d.code[8] :
		spca_pkg::rd_after(d.rdIn, d.code);
	assign d.lane.comma = commaHit;
endmodule // spca_decoder

// ===== rtl/spca_top.sv
// Line coding, word alignment and clock correction for one channel
//
// The plain strobed port and the register offsets were left to the implementer.

module spca_top (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [2:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdata,
	input  wire logic [15:0] txData,
	input  wire logic [1:0]  txCtrl,
	input  wire logic [1:0]  tx_disparity_force_mode,
	input  wire logic [1:0]  tx_disparity_force_value,
	output logic             txTake,
	output logic      [1:0]  tx_ctrl_char_error,
	output logic             txSerial,
	input  wire logic        rxSerial,
	input  wire logic        recovered_clock,
	input  wire logic        fabric_rx_clock,
	output logic      [15:0] rx_byte_out,
	output logic      [1:0]  rx_ctrl_char_flag,
	output logic      [1:0]  rx_running_disparity,
	output logic      [1:0]  rxDispErr,
	output logic      [1:0]  rxOobErr,
	output logic      [1:0]  rxCommaDet,
	output logic             rxAlignComma,
	output logic             rxRealign,
	output logic             rxWordStrobe
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	spca_pkg::spca_ctrl_type ctrl_reg;
	logic [19:0]             alignPat_reg;
	logic [17:0]             corrSeq_reg;
	spca_pkg::spca_thr_type  thr_reg;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= '0;
			alignPat_reg <= 20'h00000;
			corrSeq_reg <= spca_pkg::CORR_RST;
			thr_reg <= {spca_pkg::HIGH_RST, spca_pkg::LOW_RST};
		end else if (regWrite) begin
			if (regAddr == spca_pkg::REG_CTRL)
				ctrl_reg <= spca_pkg::spca_ctrl_type'(regWdata[11:0]);
			if (regAddr == spca_pkg::REG_ALIGN)
				alignPat_reg <= regWdata[19:0];
			if (regAddr == spca_pkg::REG_CORR)
				corrSeq_reg <= regWdata[17:0];
			if (regAddr == spca_pkg::REG_THR)
				thr_reg <= spca_pkg::spca_thr_type'(regWdata[9:0]);
		end
	end

	// ------------------------------------------------------------
	// Transmit encode and serialise
	// ------------------------------------------------------------
	logic [3:0]  divCnt_reg;
	logic [4:0]  txIdx_reg;
	logic [19:0] txShift_reg;
	logic        txRd_reg;
	wire         bitEn = divCnt_reg == spca_pkg::BIT_DIV_LAST;
	wire         txLoad = bitEn && txIdx_reg == spca_pkg::WORD_LAST;
	// Forced or inverted disparity per byte
	wire         rdIn1 = tx_disparity_force_mode[1] ?
		tx_disparity_force_value[1] :
		txRd_reg ^ tx_disparity_force_value[1];
	wire [9:0]   enc1 = spca_pkg::enc8b10b(rdIn1, txCtrl[1],
		txData[15:8]);
	wire         rdMid = spca_pkg::rd_after(rdIn1, enc1);
	wire         rdIn0 = tx_disparity_force_mode[0] ?
		tx_disparity_force_value[0] :
		rdMid ^ tx_disparity_force_value[0];
	wire [9:0]   enc0 = spca_pkg::enc8b10b(rdIn0, txCtrl[0],
		txData[7:0]);
	wire [9:0]   raw1 = {tx_disparity_force_mode[1],
		tx_disparity_force_value[1], txData[15:8]};
	wire [9:0]   raw0 = {tx_disparity_force_mode[0],
		tx_disparity_force_value[0], txData[7:0]};
	wire [19:0]  txWord = ctrl_reg.encBypass ? {raw1, raw0} :
		{enc1, enc0};
	wire [1:0]   kErr = {txCtrl[1] && !spca_pkg::ctrl_legal(txData[15:8]),
		txCtrl[0] && !spca_pkg::ctrl_legal(txData[7:0])};

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			divCnt_reg <= 4'h0;
		else
			divCnt_reg <= bitEn ? 4'h0 : divCnt_reg + 4'h1;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			txIdx_reg <= spca_pkg::WORD_LAST;
			txShift_reg <= 20'h00000;
			txSerial <= 1'b0;
			txRd_reg <= 1'b0;
		end else if (txLoad) begin
			txIdx_reg <= 5'h00;
			txShift_reg <= txWord;
			txSerial <= txWord[19];
			txRd_reg <= spca_pkg::rd_after(rdIn0, enc0);
		end else if (bitEn) begin
			txIdx_reg <= txIdx_reg + 5'h01;
			txShift_reg <= {txShift_reg[18:0], 1'b0};
			txSerial <= txShift_reg[18];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			txTake <= 1'b0;
			tx_ctrl_char_error <= 2'h0;
		end else begin
			txTake <= txLoad;
			if (txLoad)
				tx_ctrl_char_error <= ctrl_reg.encBypass ? 2'h0 : kErr;
		end
	end

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic rcSync1;
	logic rcSync2;
	logic rcSync3;
	logic dSync1;
	logic dSync2;
	logic frSync1;
	logic frSync2;
	logic frSync3;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{rcSync1, rcSync2, rcSync3} <= 3'h0;
			{dSync1, dSync2} <= 2'h0;
			{frSync1, frSync2, frSync3} <= 3'h0;
		end else begin
			{rcSync1, rcSync2, rcSync3} <= {recovered_clock, rcSync1, rcSync2};
			{dSync1, dSync2} <= {rxSerial, dSync1};
			{frSync1, frSync2, frSync3} <= {fabric_rx_clock, frSync1, frSync2};
		end
	end

	wire rcEdge = rcSync2 & ~rcSync3;
	wire frEdge = frSync2 & ~frSync3;

	// ------------------------------------------------------------
	// Word alignment and character framing
	// ------------------------------------------------------------
	logic [9:0] rxShift_reg;
	logic [3:0] rxCnt_reg;
	logic       phase_reg;
	logic [9:0] rxHi_reg;
	logic       rxRd_reg;
	logic       alignHit;
	wire [9:0]  rxShiftNext = {rxShift_reg[8:0], dSync2};
	wire        apos = rxShiftNext[9:3] == spca_pkg::COMMA_POS;
	wire        aneg = rxShiftNext[9:3] == spca_pkg::COMMA_NEG;
	wire        onBound = rxCnt_reg == spca_pkg::CHAR_LAST;
	wire        charDone = rcEdge && (onBound || alignHit);
	wire        realign = rcEdge && alignHit && !onBound;
	wire        wordDone = charDone && phase_reg && !realign;

	always_comb begin
		unique case (ctrl_reg.alignSel)
			spca_pkg::AL_OFF:  alignHit = 1'b0;
			spca_pkg::AL_POS:  alignHit = apos;
			spca_pkg::AL_NEG:  alignHit = aneg;
			spca_pkg::AL_BOTH: alignHit = apos | aneg;
			spca_pkg::AL_USER: alignHit = rxShiftNext == alignPat_reg[9:0] ||
				rxShiftNext == alignPat_reg[19:10];
			default:           alignHit = 1'b0;
		endcase
	end

	// Every bit is checked, not just the first hit
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rxShift_reg <= 10'h000;
			rxCnt_reg <= 4'h0;
			phase_reg <= 1'b0;
			rxHi_reg <= 10'h000;
		end else if (rcEdge) begin
			rxShift_reg <= rxShiftNext;
			rxCnt_reg <= charDone ? 4'h0 : rxCnt_reg + 4'h1;
			if (charDone) begin
				phase_reg <= realign ? 1'b1 : ~phase_reg;
				if (realign || !phase_reg)
					rxHi_reg <= rxShiftNext;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rxAlignComma <= 1'b0;
			rxRealign <= 1'b0;
		end else begin
			rxAlignComma <= rcEdge & alignHit;
			rxRealign <= realign;
		end
	end

	// ------------------------------------------------------------
	// Lane decoders
	// ------------------------------------------------------------
	spca_dec_if decIf1 ();
	spca_dec_if decIf0 ();
	assign decIf1.bypass = ctrl_reg.decBypass;
	assign decIf1.commaSel = ctrl_reg.commaSel;
	assign decIf1.code = rxHi_reg;
	assign decIf1.rdIn = rxRd_reg;
	assign decIf0.bypass = ctrl_reg.decBypass;
	assign decIf0.commaSel = ctrl_reg.commaSel;
	assign decIf0.code = rxShiftNext;
	assign decIf0.rdIn = decIf1.lane.rd;

	spca_decoder dec1 (
		.d (decIf1.dec)
	);
	spca_decoder dec0 (
		.d (decIf0.dec)
	);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rxRd_reg <= 1'b0;
		else if (wordDone)
			rxRd_reg <= decIf0.lane.rd;
	end

	// ------------------------------------------------------------
	// Elastic buffer and clock correction
	// ------------------------------------------------------------
	spca_pkg::spca_entry_type mem [spca_pkg::DEPTH];
	spca_pkg::spca_state_type state_reg;
	logic [4:0]               wrPtr_reg;
	logic [4:0]               rdPtr_reg;
	logic [3:0]               wait_reg;

	function automatic logic is_seq(input spca_pkg::spca_entry_type e,
		input logic [17:0] s);
		is_seq = {e[1].ctrl, e[1].data, e[0].ctrl, e[0].data} == s;
	endfunction

	wire [4:0] occ = wrPtr_reg - rdPtr_reg;
	wire [4:0] ptr1 = rdPtr_reg + 5'h01;
	wire       waitOk = wait_reg == 4'h0;
	wire       curSeq = is_seq(mem[rdPtr_reg[3:0]], corrSeq_reg);
	wire       nxtSeq = is_seq(mem[ptr1[3:0]], corrSeq_reg);
	wire       doRead = frEdge && state_reg == spca_pkg::RUN;
	wire       repeatGo = waitOk && curSeq && occ < thr_reg.low;
	wire       skip1 = waitOk && curSeq && occ > thr_reg.high;
	wire       skip2 = skip1 && ctrl_reg.repeatWait == 4'h0 && nxtSeq &&
		{1'b0, occ} > {1'b0, thr_reg.high} + 6'h01;
	wire [4:0] readIdx = skip2 ? rdPtr_reg + 5'h02 :
		(skip1 ? ptr1 : rdPtr_reg);
	wire       corr = repeatGo | skip1;
	spca_pkg::spca_entry_type rdEnt;
	assign rdEnt = mem[readIdx[3:0]];

	always_ff @(posedge mclk) begin
		if (wordDone)
			mem[wrPtr_reg[3:0]] <= {decIf1.lane, decIf0.lane};
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			wrPtr_reg <= 5'h00;
		else if (wordDone)
			wrPtr_reg <= wrPtr_reg + 5'h01;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= spca_pkg::FILL;
			rdPtr_reg <= 5'h00;
			wait_reg <= 4'h0;
		end else begin
			unique case (state_reg)
				spca_pkg::FILL: begin
					if (occ >= spca_pkg::HALF)
						state_reg <= spca_pkg::RUN;
				end
				spca_pkg::RUN: begin
					if (frEdge) begin
						rdPtr_reg <= repeatGo ? rdPtr_reg :
							readIdx + 5'h01;
						if (corr)
							wait_reg <= ctrl_reg.repeatWait;
						else if (!waitOk)
							wait_reg <= wait_reg - 4'h1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Fabric receive outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_byte_out <= 16'h0000;
			rx_ctrl_char_flag <= 2'h0;
			rx_running_disparity <= 2'h0;
			rxDispErr <= 2'h0;
			rxOobErr <= 2'h0;
			rxCommaDet <= 2'h0;
			rxWordStrobe <= 1'b0;
		end else begin
			rxWordStrobe <= doRead;
			if (doRead) begin
				rx_byte_out <= {rdEnt[1].data, rdEnt[0].data};
				rx_ctrl_char_flag <= {rdEnt[1].ctrl, rdEnt[0].ctrl};
				rx_running_disparity <= {rdEnt[1].rd, rdEnt[0].rd};
				rxDispErr <= {rdEnt[1].dispErr, rdEnt[0].dispErr};
				rxOobErr <= {rdEnt[1].oobErr, rdEnt[0].oobErr};
				rxCommaDet <= {rdEnt[1].comma, rdEnt[0].comma};
			end
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	wire [31:0] statWord = {24'h000000, state_reg == spca_pkg::RUN,
		txRd_reg, rxRd_reg, occ};
	wire [31:0] rdMux =
		(regAddr == spca_pkg::REG_CTRL)  ? {20'h00000, ctrl_reg} :
		(regAddr == spca_pkg::REG_ALIGN) ? {12'h000, alignPat_reg} :
		(regAddr == spca_pkg::REG_CORR)  ? {14'h0000, corrSeq_reg} :
		(regAddr == spca_pkg::REG_THR)   ? {22'h000000, thr_reg} :
		(regAddr == spca_pkg::REG_STAT)  ? statWord : 32'h00000000;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			regRdata <= 32'h00000000;
		else
			regRdata <= regRead ? rdMux : 32'h00000000;
	end
endmodule // spca_top

// ===== sim/spca_far_end.sv
// Remote transceiver sending idle comma words on the link
module spca_far_end (
	output logic      recovered_clock,
	output logic      rxSerial,
	input  wire logic corrupt,
	input  wire logic flip,
	input  wire logic slip
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] chars [4] = '{10'h0fa, 10'h2aa, 10'h305, 10'h2aa};
	logic [9:0] cur = 10'h0;
	logic       slipOld = 1'b0;
	int         idx = 0;
	int         pos = 0;
	initial recovered_clock = 1'b0;
	initial rxSerial = 1'b0;
	always #200 recovered_clock = ~recovered_clock;
	// Comma and idle pairs, freely repeatable, one bit held on slip
	always @(negedge recovered_clock) begin
		if (!slip || slipOld) begin
			if (pos == 0) begin
				cur = chars[idx];
				if (corrupt && idx == 1) cur = 10'h000;
				if (flip && idx == 2) cur = 10'h0fa;
				idx = (idx + 1) % 4;
			end
			rxSerial <= cur[9 - pos];
			pos = (pos + 1) % 10;
		end
		slipOld = slip;
	end
endmodule // spca_far_end

// ===== sim/spca_top_properties.sv
// Port-level timing checks for the coding and alignment channel
module spca_top_properties (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic [2:0]  regAddr,
	input wire logic        regRead,
	input wire logic [31:0] regRdata,
	input wire logic        txTake,
	input wire logic [1:0]  tx_ctrl_char_error,
	input wire logic        txSerial,
	input wire logic [15:0] rx_byte_out,
	input wire logic [1:0]  rx_ctrl_char_flag,
	input wire logic [1:0]  rxOobErr,
	input wire logic        rxAlignComma,
	input wire logic        rxRealign,
	input wire logic        rxWordStrobe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_take_gap; txTake |=> !txTake [*8]; endproperty
	a_take_gap: assert property (p_take_gap)
		else $error("load pulses too close");
	property p_bit_hold; $changed(txSerial) |=> $stable(txSerial) [*7];
	endproperty
	a_bit_hold: assert property (p_bit_hold)
		else $error("serial bit held under eight cycles");
	property p_err_load; $changed(tx_ctrl_char_error) |-> txTake; endproperty
	a_err_load: assert property (p_err_load)
		else $error("control error changed outside a load");
	property p_rd_idle;
		(!$past(regRead) || $past(regAddr) > 3'h4) |-> regRdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero");
	property p_rx_hold;
		!rxWordStrobe |-> $stable({rx_byte_out, rx_ctrl_char_flag, rxOobErr});
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("receive outputs moved without strobe");
	property p_strobe; rxWordStrobe |=> !rxWordStrobe; endproperty
	a_strobe: assert property (p_strobe)
		else $error("word strobe longer than one cycle");
	property p_align; rxAlignComma |=> !rxAlignComma; endproperty
	a_align: assert property (p_align)
		else $error("align pulse longer than one cycle");
	property p_realign; rxRealign |-> rxAlignComma; endproperty
	a_realign: assert property (p_realign)
		else $error("realign without alignment match");
endmodule // spca_top_properties

bind spca_top spca_top_properties u_spca_top_properties (.mclk, .rst_b,
	.regAddr, .regRead, .regRdata, .txTake, .tx_ctrl_char_error,
	.txSerial, .rx_byte_out, .rx_ctrl_char_flag, .rxOobErr, .rxAlignComma,
	.rxRealign, .rxWordStrobe);

// ===== sim/spca_top_test.sv
// Self-checking bench for the coding and alignment channel
module spca_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [2:0]  regAddr = 3'h0;
	logic [31:0] regWdata = 32'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [15:0] txData = 16'h0;
	logic [1:0]  txCtrl = 2'h0;
	logic [1:0]  fMode = 2'h0;
	logic [1:0]  fVal = 2'h0;
	logic        fab = 1'b0;
	logic        corrupt = 1'b0;
	logic        flip = 1'b0;
	logic        slip = 1'b0;
	logic        watch = 1'b0;
	logic [31:0] regRdata, rv;
	logic [15:0] rxByte;
	logic [1:0]  txErr, rxK, rxRd, rxDe, rxOob, rxCd;
	logic        txTake, txSerial, rxSerial, recClk, alC, realn, strb;
	logic [19:0] bits;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          fabHalf = 4000;
	int          nAl = 0;
	int          nRe = 0;
	int          nOob = 0;
	int          nDe = 0;
	int          nBad = 0;
	int          base = 0;
	always #25 mclk = ~mclk;
	always #(fabHalf) fab = ~fab;
	spca_top u_spca_top (.mclk, .rst_b, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata, .txData, .txCtrl,
		.tx_disparity_force_mode(fMode), .tx_disparity_force_value(fVal),
		.txTake, .tx_ctrl_char_error(txErr), .txSerial, .rxSerial,
		.recovered_clock(recClk), .fabric_rx_clock(fab),
		.rx_byte_out(rxByte), .rx_ctrl_char_flag(rxK),
		.rx_running_disparity(rxRd), .rxDispErr(rxDe), .rxOobErr(rxOob),
		.rxCommaDet(rxCd), .rxAlignComma(alC), .rxRealign(realn),
		.rxWordStrobe(strb));
	spca_far_end u_spca_far_end (.recovered_clock(recClk), .rxSerial,
		.corrupt, .flip, .slip);
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		rv = regRdata;
	endtask
	task automatic rdChk(input logic [2:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask
	task automatic waitTake();
		do begin @(posedge mclk); #1; end while (txTake !== 1'b1);
	endtask
	task automatic txWord(input logic [15:0] d, input logic [1:0] k, m, v);
		waitTake();
		@(posedge mclk);
		txData <= d;
		txCtrl <= k;
		fMode <= m;
		fVal <= v;
		waitTake();
		for (int i = 0; i < 20; i++) begin
			bits = {bits[18:0], txSerial};
			repeat (8) @(posedge mclk);
			#1;
		end
	endtask
	// Receive word monitor and run limit
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		nAl <= nAl + 32'(alC === 1'b1);
		nRe <= nRe + 32'(realn === 1'b1);
		if (strb === 1'b1 && rxOob[0] === 1'b1 && {rxK[0], rxByte[7:0]} === 9'h0)
			nOob <= nOob + 1;
		if (strb === 1'b1 && rxDe !== 2'h0)
			nDe <= nDe + 1;
		if (strb === 1'b1 && watch && ({rxByte, rxK, rxOob, rxDe} !==
			22'h2f2d60 || rxRd[0] !== rxRd[1] || rxCd !== 2'b10))
			nBad <= nBad + 1;
		if (cyc == 90000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		rdChk(3'h2, 32'h000378b5);
		rdChk(3'h3, 32'h00000146);
		wr(3'h5, 32'hffffffff);
		rdChk(3'h5, 32'h0);
		wr(3'h1, 32'h000c14fa);
		wr(3'h0, 32'h00000094);
		rdChk(3'h0, 32'h00000094);
		txWord(16'hbc00, 2'b11, 2'b00, 2'b00);
		chk(bits[19:10], 10'h0fa);
		chk(txErr, 2'b01);
		txWord(16'hbcbc, 2'b11, 2'b10, 2'b10);
		chk(bits[19:10], 10'h305);
		chk(txErr, 2'b00);
		wr(3'h0, 32'h00000095);
		txWord(16'h5ac3, 2'b00, 2'b10, 2'b01);
		chk(bits, 20'h969c3);
		repeat (1000) @(posedge mclk);
		watch = 1'b1;
		fabHalf = 3800;
		repeat (16000) @(posedge mclk);
		rd(3'h4);
		chk({31'h0, rv[4:0] >= 5'h04}, 32'h1);
		chk(rv[7], 1'b1);
		fabHalf = 4200;
		repeat (24000) @(posedge mclk);
		rd(3'h4);
		chk({31'h0, rv[4:0] <= 5'h0c}, 32'h1);
		chk(nBad, 32'h0);
		watch = 1'b0;
		fabHalf = 4000;
		corrupt = 1'b1;
		repeat (400) @(posedge mclk);
		corrupt = 1'b0;
		flip = 1'b1;
		repeat (400) @(posedge mclk);
		flip = 1'b0;
		repeat (1600) @(posedge mclk);
		chk({31'h0, nOob != 0}, 32'h1);
		chk({31'h0, nDe != 0}, 32'h1);
		base = nRe;
		slip = 1'b1;
		repeat (1600) @(posedge mclk);
		slip = 1'b0;
		chk(nRe - base, 32'h1);
		chk({31'h0, nAl > 20}, 32'h1);
		wr(3'h0, 32'h00000068);
		base = nRe;
		slip = 1'b1;
		repeat (3200) @(posedge mclk);
		slip = 1'b0;
		do begin @(posedge mclk); #1; end while (strb !== 1'b1);
		chk(nRe - base, 32'h1);
		chk({rxCd, rxK, rxByte}, 20'habcb5);
		wr(3'h0, 32'h00000096);
		repeat (3200) @(posedge mclk);
		do begin @(posedge mclk); #1; end while (strb !== 1'b1);
		chk({rxK[0], rxRd[0], rxByte[7:0]}, 10'h2aa);
		wr(3'h0, 32'h00000014);
		base = nRe;
		slip = 1'b1;
		repeat (1600) @(posedge mclk);
		chk(nRe - base, 32'h0);
		end_of_test();
	end
endmodule // spca_top_test
